// file: rtl/ppol_flip.sv
// Registered polarity stage: every bit leaves as raw XOR mask.
// Assumes raw inputs are synchronous to the clock.
module ppol_flip #(
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic srst_in,
    // Data path.
    input wire logic [W-1:0] raw_in,
    input wire logic [W-1:0] mask_in,
    output logic [W-1:0] data_out
);

    typedef struct packed {
        logic [W-1:0] data;
    } ppol_flip_s;

    ppol_flip_s state;
    ppol_flip_s next_state;

    // One XOR per pin; the register keeps pin outputs glitch free.
    always_comb begin
        next_state.data = raw_in ^ mask_in;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign data_out = state.data;

endmodule : ppol_flip

// file: rtl/ppol_pkg.sv
// Shared constants and carriers for the port pin polarity and interrupt
// summary block.
// Assumes a 16-bit register view packed into the low half of each
// 32-bit Wishbone word, one word per register index.
package ppol_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_TX_INV = 10'h04A;
    localparam logic [9:0] IDX_RX_INV = 10'h04C;
    localparam logic [9:0] IDX_ISR = 10'h050;
    localparam logic [9:0] IDX_SR = 10'h052;
    localparam logic [9:0] IDX_SRL = 10'h054;
    localparam logic [9:0] IDX_SRIE = 10'h056;
    localparam logic [9:0] IDX_GIE = 10'h058;

    // Writable bits of the polarity registers; the rest read as zero.
    localparam logic [15:0] TX_INV_MASK = 16'h17FF;
    localparam logic [15:0] RX_INV_MASK = 16'h16DE;
    localparam logic [15:0] INV_RESET = 16'h0000;
    // Live and latched port status use bits 2..0.
    localparam logic [15:0] SR_MASK = 16'h0007;
    localparam logic [15:0] GIE_MASK = 16'h0001;

    // Summary register bit positions.
    localparam int ISR_PORT = 9;
    localparam int ISR_LINE = 8;
    localparam int ISR_TRAIL = 7;
    localparam int ISR_FAREND = 6;
    localparam int ISR_HDLC = 5;
    localparam int ISR_BERT = 4;
    localparam int ISR_FRAMER = 0;

    // Transmit pins, one field per bit of the transmit invert register.
    typedef struct packed {
        logic rsvd15;
        logic rsvd14;
        logic rsvd13;
        logic tx_frame_pulse_out;
        logic rsvd11;
        logic tx_serial_in;
        logic tx_overhead_frame_pulse;
        logic tx_overhead_enable;
        logic tx_overhead_data;
        logic tx_overhead_clock;
        logic tx_frame_pulse_in;
        logic tx_negative_rail;
        logic tx_positive_rail_data;
        logic tx_line_clock;
        logic tx_clock_out;
        logic tx_clock_in;
    } ppol_tx_s;

    // Receive pins, one field per bit of the receive invert register.
    typedef struct packed {
        logic rsvd15;
        logic rsvd14;
        logic rsvd13;
        logic rx_frame_pulse_out;
        logic rsvd11;
        logic rx_serial_out;
        logic rx_overhead_frame_pulse;
        logic rsvd8;
        logic rx_overhead_data;
        logic rx_overhead_clock;
        logic rsvd5;
        logic rx_negative_rail;
        logic rx_positive_rail;
        logic rx_line_clock;
        logic rx_clock_out;
        logic rsvd0;
    } ppol_rx_s;

    // Live port status, in register bit order 2..0.
    typedef struct packed {
        logic tx_driver_overload;
        logic rx_loss_of_lock;
        logic perf_update_done;
    } ppol_status_s;

    // Enabled-and-latched summaries from the other sub-blocks.
    typedef struct packed {
        logic line_code_summary;
        logic trail_trace_summary;
        logic far_end_alarm_summary;
        logic hdlc_summary;
        logic bert_summary;
        logic framer_summary;
    } ppol_sub_s;

endpackage : ppol_pkg

// file: rtl/ppol_top.sv
// Port pin polarity controls, live and latched port status, and the
// port interrupt summary, reached over a classic Wishbone slave.
// Assumes all pin and status inputs are synchronous to CLK_IN and that
// the other sub-blocks present their own enabled latched summaries.
//
// Overview of operation
// - Tx bit 12 flips frame pulse / data enable
// - Tx bit 10 complements sampled serial data
// - Tx bits 9, 8 flip overhead frame, enable
// - Tx bits 7, 6 flip overhead data, clock
// - Tx bit 5 flips frame pulse input
// - Tx bits 4, 3 flip negative, positive rails
// - Tx bit 2 flips line clock
// - Tx bit 1 flips clock out / gapped clock
// - Tx bit 0 flips clock input
// - Rx bit 12 flips frame pulse / data enable
// - Rx bit 10 complements driven serial data
// - Rx bits 9, 7, 6 flip overhead pins
// - Rx bits 4, 3 flip line rails
// - Rx bit 2 flips line clock
// - Rx bit 1 flips clock out / gapped clock
// - Summary bit 9: any enabled latched port status
// - Summary bit 8: line code block pending
// - Summary bits 7, 6: trail trace, far end
// - Summary bits 5, 4: HDLC, BERT
// - Summary bit 0: active framer pending
// - Interrupt when any summary and global enable
// - Status bit 2 shows driver overload live
// - Status bit 1 shows loss of lock
// - Latched bit sets on live rising edge
module ppol_top #(
    parameter int ADR_W = 12
) (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    // Wishbone slave.
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Transmit pins: raw values in, polarity-corrected values out.
    input wire ppol_pkg::ppol_tx_s TX_RAW_IN,
    output ppol_pkg::ppol_tx_s TX_FLIP_OUT,
    // Receive pins: raw values in, polarity-corrected values out.
    input wire ppol_pkg::ppol_rx_s RX_RAW_IN,
    output ppol_pkg::ppol_rx_s RX_FLIP_OUT,
    // Live status and sub-block summaries.
    input wire ppol_pkg::ppol_status_s STATUS_IN,
    input wire ppol_pkg::ppol_sub_s SUB_IRQ_IN,
    // Interrupt.
    output logic IRQ_OUT
);

    // Registered state of the block, apart from the ack and the two polarity stages.
    typedef struct packed {
        logic [15:0] tx_inv;
        logic [15:0] rx_inv;
        logic [2:0] live_prev;
        logic [2:0] latched;
        logic [2:0] latch_en;
        logic global_en;
        logic [31:0] rdata;
        logic irq;
    } ppol_state_s;

    ppol_state_s state;
    ppol_state_s next_state;

    logic take;
    logic ack;
    logic wr_commit;
    logic [9:0] idx;
    logic [15:0] isr_value;
    logic [15:0] sr_value;
    logic [15:0] read_value;
    logic port_summary;
    logic [2:0] rise;
    logic [2:0] clear_req;
    logic [15:0] tx_flip;
    logic [15:0] rx_flip;
    // Field views of the two polarity stages.
    ppol_pkg::ppol_tx_s tx_view;
    ppol_pkg::ppol_rx_s rx_view;

    // Merge the enabled byte lanes of the write data into a 16-bit
    // register; bits outside the mask stay zero.
    function automatic logic [15:0] ppol_merge(
        input logic [15:0] old,
        input logic [31:0] wdat,
        input logic [3:0] sel,
        input logic [15:0] mask
    );
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res & mask;
    endfunction : ppol_merge

    // Handshake: the ack arrives one cycle after the request is taken.
    ppol_wb_ack u_ack (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .cyc_in(WB_CYC_IN),
        .stb_in(WB_STB_IN),
        .take_out(take),
        .ack_out(ack)
    );

    // Register index decoded from the byte address.
    assign idx = 10'(WB_ADR_IN[ADR_W-1:2]);

    // Writes commit at the edge where the master sees ack, so a request
    // withdrawn early never half-updates a register.
    assign wr_commit = ack & WB_CYC_IN & WB_STB_IN & WB_WE_IN;

    // A rising live bit latches.
    assign rise = STATUS_IN & ~state.live_prev;

    // Latched port status is cleared by writing ones to it.
    always_comb begin
        clear_req = '0;
        if (wr_commit && idx == ppol_pkg::IDX_SRL && WB_SEL_IN[0]) begin
            clear_req = WB_DAT_IN[2:0];
        end
    end

    // Port status summary: enabled latched port status pending.
    assign port_summary = |(state.latched & state.latch_en);

    // Summary register assembled from live inputs; it holds no state of
    // its own, so it clears as soon as its sources clear.
    always_comb begin
        isr_value = '0;
        isr_value[ppol_pkg::ISR_PORT] = port_summary;
        isr_value[ppol_pkg::ISR_LINE] =
            SUB_IRQ_IN.line_code_summary;
        isr_value[ppol_pkg::ISR_TRAIL] =
            SUB_IRQ_IN.trail_trace_summary;
        isr_value[ppol_pkg::ISR_FAREND] =
            SUB_IRQ_IN.far_end_alarm_summary;
        isr_value[ppol_pkg::ISR_HDLC] = SUB_IRQ_IN.hdlc_summary;
        isr_value[ppol_pkg::ISR_BERT] = SUB_IRQ_IN.bert_summary;
        isr_value[ppol_pkg::ISR_FRAMER] =
            SUB_IRQ_IN.framer_summary;
    end

    // Live port status shows the inputs as they stand.
    always_comb begin
        sr_value = '0;
        sr_value[2] = STATUS_IN.tx_driver_overload;
        sr_value[1] = STATUS_IN.rx_loss_of_lock;
        sr_value[0] = STATUS_IN.perf_update_done;
    end

    // Read multiplexer; unmapped indices read as zero but still ack.
    always_comb begin
        read_value = '0;
        unique case (idx)
            ppol_pkg::IDX_TX_INV: read_value = state.tx_inv;
            ppol_pkg::IDX_RX_INV: read_value = state.rx_inv;
            ppol_pkg::IDX_ISR: read_value = isr_value;
            ppol_pkg::IDX_SR: read_value = sr_value;
            ppol_pkg::IDX_SRL: read_value = {13'h0000, state.latched};
            ppol_pkg::IDX_SRIE: read_value = {13'h0000, state.latch_en};
            ppol_pkg::IDX_GIE: read_value = {15'h0000, state.global_en};
            default: read_value = '0;
        endcase
    end

    // Next state of this module's own registers; the ack and polarity stages keep theirs.
    always_comb begin
        next_state = state;
        next_state.live_prev = STATUS_IN;
        // Set wins over a clear arriving in the same cycle.
        next_state.latched = (state.latched & ~clear_req) | rise;
        if (take) begin
            next_state.rdata = {16'h0000, read_value};
        end
        if (wr_commit) begin
            // Summary and live status are not in this list, so writes
            // to them fall through with no effect.
            unique case (idx)
                ppol_pkg::IDX_TX_INV: begin
                    next_state.tx_inv = ppol_merge(state.tx_inv,
                        WB_DAT_IN, WB_SEL_IN, ppol_pkg::TX_INV_MASK);
                end
                ppol_pkg::IDX_RX_INV: begin
                    next_state.rx_inv = ppol_merge(state.rx_inv,
                        WB_DAT_IN, WB_SEL_IN, ppol_pkg::RX_INV_MASK);
                end
                ppol_pkg::IDX_SRIE: begin
                    next_state.latch_en = 3'(ppol_merge(
                        {13'h0000, state.latch_en}, WB_DAT_IN,
                        WB_SEL_IN, ppol_pkg::SR_MASK));
                end
                ppol_pkg::IDX_GIE: begin
                    next_state.global_en = 1'(ppol_merge(
                        {15'h0000, state.global_en}, WB_DAT_IN,
                        WB_SEL_IN, ppol_pkg::GIE_MASK));
                end
                default: begin
                    next_state.global_en = state.global_en;
                end
            endcase
        end
        // Interrupt: any summary bit gated by the global enable.
        next_state.irq = (|isr_value) & next_state.global_en;
    end

    // State register; live_prev starts low so a status that is already
    // high out of reset is seen as a rising edge one cycle later.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state.tx_inv <= ppol_pkg::INV_RESET;
            state.rx_inv <= ppol_pkg::INV_RESET;
            state.live_prev <= '0;
            state.latched <= '0;
            state.latch_en <= '0;
            state.global_en <= 1'b0;
            state.rdata <= '0;
            state.irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Transmit polarity stage; each pin bit is XORed with its control.
    // Outputs and inputs share one stage since their bit slots differ.
    ppol_flip #(
        .W(16)
    ) u_tx_flip (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .raw_in(TX_RAW_IN),
        .mask_in(state.tx_inv),
        .data_out(tx_flip)
    );

    // Transmit invert register bits 5..0 cover frame input, rails and
    // clocks; the same XOR stage serves them.

    // Receive polarity stage, same structure as transmit.
    ppol_flip #(
        .W(16)
    ) u_rx_flip (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .raw_in(RX_RAW_IN),
        .mask_in(state.rx_inv),
        .data_out(rx_flip)
    );

    // Receive rails and clocks share the stage above.

    // Transmit pins leave field by field, so each control bit can be
    // traced to the pin that it serves. Reserved slots carry the raw bit
    // through unchanged, since their mask bits can never be set.
    always_comb begin
        tx_view = ppol_pkg::ppol_tx_s'(tx_flip);
        TX_FLIP_OUT.rsvd15 = tx_view.rsvd15;
        TX_FLIP_OUT.rsvd14 = tx_view.rsvd14;
        TX_FLIP_OUT.rsvd13 = tx_view.rsvd13;
        // Framer and overhead side.
        TX_FLIP_OUT.tx_frame_pulse_out =
            tx_view.tx_frame_pulse_out;
        TX_FLIP_OUT.rsvd11 = tx_view.rsvd11;
        TX_FLIP_OUT.tx_serial_in =
            tx_view.tx_serial_in;
        TX_FLIP_OUT.tx_overhead_frame_pulse =
            tx_view.tx_overhead_frame_pulse;
        TX_FLIP_OUT.tx_overhead_enable =
            tx_view.tx_overhead_enable;
        TX_FLIP_OUT.tx_overhead_data =
            tx_view.tx_overhead_data;
        TX_FLIP_OUT.tx_overhead_clock =
            tx_view.tx_overhead_clock;
        TX_FLIP_OUT.tx_frame_pulse_in =
            tx_view.tx_frame_pulse_in;
        // Line side: rails and clocks.
        TX_FLIP_OUT.tx_negative_rail =
            tx_view.tx_negative_rail;
        TX_FLIP_OUT.tx_positive_rail_data =
            tx_view.tx_positive_rail_data;
        TX_FLIP_OUT.tx_line_clock =
            tx_view.tx_line_clock;
        TX_FLIP_OUT.tx_clock_out =
            tx_view.tx_clock_out;
        TX_FLIP_OUT.tx_clock_in =
            tx_view.tx_clock_in;
    end

    // Receive pins, laid out the same way; the receive register has more
    // reserved slots, and those pass the raw bit as well.
    always_comb begin
        rx_view = ppol_pkg::ppol_rx_s'(rx_flip);
        RX_FLIP_OUT.rsvd15 = rx_view.rsvd15;
        RX_FLIP_OUT.rsvd14 = rx_view.rsvd14;
        RX_FLIP_OUT.rsvd13 = rx_view.rsvd13;
        // Framer and overhead side.
        RX_FLIP_OUT.rx_frame_pulse_out =
            rx_view.rx_frame_pulse_out;
        RX_FLIP_OUT.rsvd11 = rx_view.rsvd11;
        RX_FLIP_OUT.rx_serial_out =
            rx_view.rx_serial_out;
        RX_FLIP_OUT.rx_overhead_frame_pulse =
            rx_view.rx_overhead_frame_pulse;
        RX_FLIP_OUT.rsvd8 = rx_view.rsvd8;
        RX_FLIP_OUT.rx_overhead_data =
            rx_view.rx_overhead_data;
        RX_FLIP_OUT.rx_overhead_clock =
            rx_view.rx_overhead_clock;
        RX_FLIP_OUT.rsvd5 = rx_view.rsvd5;
        // Line side: rails and clocks.
        RX_FLIP_OUT.rx_negative_rail =
            rx_view.rx_negative_rail;
        RX_FLIP_OUT.rx_positive_rail =
            rx_view.rx_positive_rail;
        RX_FLIP_OUT.rx_line_clock =
            rx_view.rx_line_clock;
        RX_FLIP_OUT.rx_clock_out =
            rx_view.rx_clock_out;
        RX_FLIP_OUT.rsvd0 = rx_view.rsvd0;
    end

    // Bus answer.
    assign WB_ACK_OUT = ack;
    assign WB_DAT_OUT = state.rdata;
    assign IRQ_OUT = state.irq;

endmodule : ppol_top

// file: rtl/ppol_wb_ack.sv
// Classic Wishbone handshake: one ack per request, dropped next cycle.
// Assumes the master holds cyc and stb until it samples ack.
module ppol_wb_ack (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic srst_in,
    // Bus strobes.
    input wire logic cyc_in,
    input wire logic stb_in,
    output logic take_out,
    output logic ack_out
);

    typedef struct packed {
        logic ack;
    } ppol_ack_s;

    ppol_ack_s state;
    ppol_ack_s next_state;

    // Take a request only while no ack stands, so each one answers once.
    always_comb begin
        take_out = cyc_in & stb_in & ~state.ack;
        next_state.ack = take_out;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign ack_out = state.ack;

endmodule : ppol_wb_ack

// file: verif/ppol_far_model.sv
// Far-side model: framer and line logic driving raw pins and summaries.
// Assumes the bench commands the status and summary levels.
module ppol_far_model (
    // Clock.
    input wire logic clk_in,
    // Commanded levels.
    input wire ppol_pkg::ppol_status_s status_cmd_in,
    input wire ppol_pkg::ppol_sub_s sub_cmd_in,
    // Levels seen by the block.
    output ppol_pkg::ppol_tx_s tx_raw_out,
    output ppol_pkg::ppol_rx_s rx_raw_out,
    output ppol_pkg::ppol_status_s status_out,
    output ppol_pkg::ppol_sub_s sub_out
);
    timeunit 1ns;
    timeprecision 1ns;
    integer seed = 72;
    initial begin
        tx_raw_out = '0;
        rx_raw_out = '0;
        status_out = '0;
        sub_out = '0;
    end
    // Pins change at random every cycle so each flip is seen both ways.
    always @(posedge clk_in) begin
        tx_raw_out <= 16'($random(seed));
        rx_raw_out <= 16'($random(seed));
        status_out <= status_cmd_in;
        sub_out <= sub_cmd_in;
    end
endmodule : ppol_far_model

// file: verif/ppol_properties.sv
// Port checker for the polarity and interrupt summary block.
// Assumes it is bound to ppol_top and sees only that module's ports.
module ppol_props (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    // Wishbone.
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    // Pins, status and interrupt.
    input wire ppol_pkg::ppol_tx_s TX_RAW_IN,
    input wire ppol_pkg::ppol_tx_s TX_FLIP_OUT,
    input wire ppol_pkg::ppol_rx_s RX_RAW_IN,
    input wire ppol_pkg::ppol_rx_s RX_FLIP_OUT,
    input wire ppol_pkg::ppol_status_s STATUS_IN,
    input wire ppol_pkg::ppol_sub_s SUB_IRQ_IN,
    input wire logic IRQ_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);

    // A request is taken only while no answer is pending.
    sequence taken;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    endsequence
    sequence answer;
        WB_ACK_OUT ##1 !WB_ACK_OUT;
    endsequence

    chk_ack_one_cycle: assert property (taken |=> answer)
        else $error("ack not a single pulse after request");
    chk_ack_needs_req: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN))
        else $error("ack without request");
    chk_dat_upper_zero: assert property (WB_ACK_OUT |->
        WB_DAT_OUT[31:16] == 16'h0000) else $error("upper read data set");
    chk_dat_hold: assert property (!(WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT)
        |=> $stable(WB_DAT_OUT)) else $error("read data moved");
    // Reserved pin positions carry no flip and pass straight through.
    chk_tx_rsvd_pass: assert property (!$past(SRST_IN) |->
        (TX_FLIP_OUT & 16'hE800) == ($past(TX_RAW_IN) & 16'hE800))
        else $error("reserved tx bit altered");
    chk_rx_rsvd_pass: assert property (!$past(SRST_IN) |->
        (RX_FLIP_OUT & 16'hE921) == ($past(RX_RAW_IN) & 16'hE921))
        else $error("reserved rx bit altered");
    // A write to the enable or clear registers commits at the ack edge,
    // when the master is already dropping cyc, so the summary moves one
    // cycle later and the interrupt one more: look two cycles back too.
    chk_irq_has_cause: assert property ($rose(IRQ_OUT) |->
        $past(|SUB_IRQ_IN) || $past(WB_CYC_IN) || $past(WB_CYC_IN, 2) ||
        $past(|STATUS_IN, 2))
        else $error("interrupt rose without cause");
    chk_irq_fall_cause: assert property ($fell(IRQ_OUT) |->
        $past(WB_CYC_IN) || $past(WB_CYC_IN, 2) ||
        ($past(SUB_IRQ_IN, 2) & ~$past(SUB_IRQ_IN)) != 0)
        else $error("interrupt fell without cause");
endmodule : ppol_props

// file: verif/tb.sv
// Self-checking bench for the polarity and interrupt summary block.
// Assumes the package, design, far-side model and checker compile first.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rx_line_data;
    logic ack;
    logic irq;
    ppol_pkg::ppol_tx_s tx_raw, tx_out;
    ppol_pkg::ppol_rx_s rx_raw, rx_out;
    ppol_pkg::ppol_status_s st, st_cmd = 3'h0;
    ppol_pkg::ppol_sub_s sub, sub_cmd = 6'h00;
    logic [15:0] sh_tx = 16'h0000;
    logic [15:0] sh_rx = 16'h0000;
    logic [15:0] e_tx = 16'h0000;
    logic [15:0] e_rx = 16'h0000;
    logic [15:0] exp_q[$];
    int err_total = 0;
    int checks = 0;

    // Clock of 40 ns.
    always #20 clk = ~clk;

    ppol_top dut (.CLK_IN(clk), .SRST_IN(srst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(wdat), .WB_DAT_OUT(rx_line_data), .WB_ACK_OUT(ack),
        .TX_RAW_IN(tx_raw), .TX_FLIP_OUT(tx_out), .RX_RAW_IN(rx_raw),
        .RX_FLIP_OUT(rx_out), .STATUS_IN(st), .SUB_IRQ_IN(sub),
        .IRQ_OUT(irq));
    ppol_far_model far (.clk_in(clk), .status_cmd_in(st_cmd),
        .sub_cmd_in(sub_cmd), .tx_raw_out(tx_raw), .rx_raw_out(rx_raw),
        .status_out(st), .sub_out(sub));

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // One classic cycle; the shadow masks move at the ack edge, as the
    // design commits there.
    task automatic wb(input logic w, input logic [9:0] idx,
                      input logic [15:0] d, input logic [3:0] s);
        int n;
        logic [15:0] m;
        n = 0;
        m = {{8{s[1]}}, {8{s[0]}}};
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {16'h0000, d};
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        if (w && idx == ppol_pkg::IDX_TX_INV)
            sh_tx <= (sh_tx & ~m) | (d & m & ppol_pkg::TX_INV_MASK);
        if (w && idx == ppol_pkg::IDX_RX_INV)
            sh_rx <= (sh_rx & ~m) | (d & m & ppol_pkg::RX_INV_MASK);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        wb(1'b1, idx, d, 4'h3);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [15:0] e);
        exp_q.push_back(e);
        wb(1'b0, idx, 16'h0000, 4'hF);
    endtask : rd

    // Read watcher: each acked read meets the oldest noted value.
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            chk("read data", exp_q.pop_front(), rx_line_data[15:0]);
    end

    // Pin watcher: each output is last edge's raw value XOR the mask.
    always @(posedge clk) begin
        if (!srst) begin
            chk("tx_hi", 16'(e_tx[15:8]), 16'(tx_out[15:8]));
            chk("tx_mid", 16'(e_tx[7:4]), 16'(tx_out[7:4]));
            chk("tx_lo", 16'(e_tx[3:0]), 16'(tx_out[3:0]));
            chk("rx_hi", 16'(e_rx[15:8]), 16'(rx_out[15:8]));
            chk("rx_lo", 16'(e_rx[7:0]), 16'(rx_out[7:0]));
        end
        e_tx <= srst ? 16'h0000 : tx_raw ^ sh_tx;
        e_rx <= srst ? 16'h0000 : rx_raw ^ sh_rx;
    end

    // Watchdog sized well beyond the expected run of a few hundred cycles.
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        logic [15:0] r;
        logic [9:0] idxs [8] = '{10'h04A, 10'h04C, 10'h050, 10'h052,
                                 10'h054, 10'h056, 10'h058, 10'h3FF};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (idxs[i]) rd(idxs[i], 16'h0000);
        wr(10'h3FF, 16'hFFFF);
        rd(10'h3FF, 16'h0000);
        wr(ppol_pkg::IDX_TX_INV, 16'hFFFF);
        wr(ppol_pkg::IDX_RX_INV, 16'hFFFF);
        rd(ppol_pkg::IDX_TX_INV, 16'h17FF);
        rd(ppol_pkg::IDX_RX_INV, 16'h16DE);
        repeat (6) begin
            r = 16'($random(far.seed));
            wr(ppol_pkg::IDX_TX_INV, r);
            wr(ppol_pkg::IDX_RX_INV, ~r);
            repeat (4) @(posedge clk);
            rd(ppol_pkg::IDX_TX_INV, r & 16'h17FF);
            rd(ppol_pkg::IDX_RX_INV, ~r & 16'h16DE);
        end
        wr(ppol_pkg::IDX_TX_INV, 16'hFFFF);
        wb(1'b1, ppol_pkg::IDX_TX_INV, 16'h0000, 4'h2);
        rd(ppol_pkg::IDX_TX_INV, 16'h00FF);
        wr(ppol_pkg::IDX_ISR, 16'hFFFF);
        wr(ppol_pkg::IDX_SR, 16'hFFFF);
        rd(ppol_pkg::IDX_ISR, 16'h0000);
        rd(ppol_pkg::IDX_SR, 16'h0000);
        st_cmd <= 3'h4;
        repeat (3) @(posedge clk);
        rd(ppol_pkg::IDX_SR, 16'h0004);
        st_cmd <= 3'h2;
        repeat (3) @(posedge clk);
        rd(ppol_pkg::IDX_SR, 16'h0002);
        rd(ppol_pkg::IDX_SRL, 16'h0006);
        wr(ppol_pkg::IDX_SRL, 16'h0007);
        rd(ppol_pkg::IDX_SRL, 16'h0000);
        wr(ppol_pkg::IDX_SRIE, 16'h0007);
        wr(ppol_pkg::IDX_GIE, 16'h0001);
        st_cmd <= 3'h3;
        repeat (4) @(posedge clk);
        rd(ppol_pkg::IDX_ISR, 16'h0200);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(ppol_pkg::IDX_SRL, 16'h0001);
        repeat (3) @(posedge clk);
        chk("irq", 16'h0000, {15'h0000, irq});
        // Each sub-block summary in turn; framer sits at bit 0.
        for (int i = 0; i < 6; i++) begin
            sub_cmd <= 6'(6'h01 << i);
            repeat (4) @(posedge clk);
            rd(ppol_pkg::IDX_ISR, i == 0 ? 16'h0001 : 16'(1 << (i + 3)));
            chk("irq", 16'h0001, {15'h0000, irq});
        end
        wr(ppol_pkg::IDX_GIE, 16'h0000);
        repeat (3) @(posedge clk);
        chk("irq", 16'h0000, {15'h0000, irq});
        sub_cmd <= 6'h00;
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule : tb

bind ppol_top ppol_props chk_i (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
    .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_DAT_OUT(WB_DAT_OUT),
    .WB_ACK_OUT(WB_ACK_OUT), .TX_RAW_IN(TX_RAW_IN),
    .TX_FLIP_OUT(TX_FLIP_OUT), .RX_RAW_IN(RX_RAW_IN),
    .RX_FLIP_OUT(RX_FLIP_OUT), .STATUS_IN(STATUS_IN),
    .SUB_IRQ_IN(SUB_IRQ_IN), .IRQ_OUT(IRQ_OUT));
